// ===== shared/pgo_pkg.sv
// Constants shared by the port G override block and its port registers.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package pgo_pkg;

    // Widths of the ports and of the bus.
    localparam int PORT_W = 8;
    localparam int G_W    = 5;
    localparam int ADR_W  = 8;
    localparam int DAT_W  = 32;

    // Register byte offsets, one aligned word each.
    localparam logic [ADR_W-1:0] OFS_A_LATCH = 8'h00;
    localparam logic [ADR_W-1:0] OFS_A_DIR   = 8'h04;
    localparam logic [ADR_W-1:0] OFS_A_PINS  = 8'h08;
    localparam logic [ADR_W-1:0] OFS_B_LATCH = 8'h0c;
    localparam logic [ADR_W-1:0] OFS_B_DIR   = 8'h10;
    localparam logic [ADR_W-1:0] OFS_B_PINS  = 8'h14;
    localparam logic [ADR_W-1:0] OFS_C_LATCH = 8'h18;
    localparam logic [ADR_W-1:0] OFS_C_DIR   = 8'h1c;
    localparam logic [ADR_W-1:0] OFS_C_PINS  = 8'h20;
    localparam logic [ADR_W-1:0] OFS_G_LATCH = 8'h24;
    localparam logic [ADR_W-1:0] OFS_G_DIR   = 8'h28;
    localparam logic [ADR_W-1:0] OFS_G_PINS  = 8'h2c;
    localparam logic [ADR_W-1:0] OFS_CTRL    = 8'h30;

    // Control register field positions.
    localparam int CTRL_ASYNC_BIT = 0;
    localparam int CTRL_EXTCK_BIT = 1;
    localparam int CTRL_XMEM_BIT  = 2;
    localparam int CTRL_W         = 3;

    // Values after reset.
    localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
    localparam logic [G_W-1:0]    G_RST    = 5'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
    localparam logic [DAT_W-1:0]  DAT_ZERO = 32'h0000_0000;

    // Port G pin positions with alternate functions.
    localparam int G_OSC_IN  = 4;
    localparam int G_OSC_OUT = 3;
    localparam int G_ALE     = 2;
    localparam int G_RD      = 1;
    localparam int G_WR      = 0;

endpackage : pgo_pkg

// ===== design/pgo_pin_ovr.sv
// One port's pin attribute logic: register defaults with overrides on top.
// Assumes latch, direction and overrides come from logic on the same clock.
`timescale 1ns/1ps
module pgo_pin_ovr #(
    parameter int W = 8
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Port register values.
    input  wire logic [W-1:0] latch_i,
    input  wire logic [W-1:0] dir_i,
    // Override enables and values.
    input  wire logic [W-1:0] pu_oe_i,
    input  wire logic [W-1:0] pu_ov_i,
    input  wire logic [W-1:0] dd_oe_i,
    input  wire logic [W-1:0] dd_ov_i,
    input  wire logic [W-1:0] pv_oe_i,
    input  wire logic [W-1:0] pv_ov_i,
    input  wire logic [W-1:0] ie_oe_i,
    input  wire logic [W-1:0] ie_ov_i,
    // Registered pin controls.
    output logic      [W-1:0] pad_out_o,
    output logic      [W-1:0] pad_oe_o,
    output logic      [W-1:0] pullup_o,
    output logic      [W-1:0] in_en_o
);

    logic [W-1:0] pu_plain;

    // Without override, a pull-up is on for an input whose latch is one.
    assign pu_plain = latch_i & ~dir_i;

    // Each attribute takes its override value where enabled. Registering
    // here keeps pins glitch free at the cost of one cycle of latency.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_out_o <= '0;
            pad_oe_o  <= '0;
            pullup_o  <= '0;
            in_en_o   <= '1;
        end else begin
            pad_out_o <= (pv_oe_i & pv_ov_i) | (~pv_oe_i & latch_i);
            pad_oe_o  <= (dd_oe_i & dd_ov_i) | (~dd_oe_i & dir_i);
            pullup_o  <= (pu_oe_i & pu_ov_i) | (~pu_oe_i & pu_plain);
            in_en_o   <= (ie_oe_i & ie_ov_i) | ~ie_oe_i;
        end
    end

endmodule : pgo_pin_ovr

// ===== design/pgo_top.sv
// Ports A, B, C and G registers with the port G alternate overrides.
// Assumes a classic Wishbone master on clk_i and pins from outside.
`timescale 1ns/1ps
module pgo_top
    import pgo_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave.
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [DAT_W-1:0]  wb_dat_i,
    output logic      [DAT_W-1:0]  wb_dat_o,
    output logic                   wb_ack_o,
    // External memory strobes.
    input  wire logic              mem_ale_i,
    input  wire logic              mem_rd_i,
    input  wire logic              mem_wr_i,
    // Port A pins.
    input  wire logic [PORT_W-1:0] pa_in_i,
    output logic      [PORT_W-1:0] pa_out_o,
    output logic      [PORT_W-1:0] pa_oe_o,
    output logic      [PORT_W-1:0] pa_pu_o,
    // Port B pins.
    input  wire logic [PORT_W-1:0] pb_in_i,
    output logic      [PORT_W-1:0] pb_out_o,
    output logic      [PORT_W-1:0] pb_oe_o,
    output logic      [PORT_W-1:0] pb_pu_o,
    // Port C pins.
    input  wire logic [PORT_W-1:0] pc_in_i,
    output logic      [PORT_W-1:0] pc_out_o,
    output logic      [PORT_W-1:0] pc_oe_o,
    output logic      [PORT_W-1:0] pc_pu_o,
    // Port G pins.
    input  wire logic [G_W-1:0]    pg_in_i,
    output logic      [G_W-1:0]    pg_out_o,
    output logic      [G_W-1:0]    pg_oe_o,
    output logic      [G_W-1:0]    pg_pu_o,
    output logic      [G_W-1:0]    pg_ie_o,
    // Oscillator amplifier routing.
    output logic                   osc_in_route_o,
    output logic                   osc_out_route_o
);

    // Port registers.
    logic [PORT_W-1:0] pa_latch_q;
    logic [PORT_W-1:0] pa_dir_q;
    logic [PORT_W-1:0] pb_latch_q;
    logic [PORT_W-1:0] pb_dir_q;
    logic [PORT_W-1:0] pc_latch_q;
    logic [PORT_W-1:0] pc_dir_q;
    logic [G_W-1:0]    pg_latch_q;
    logic [G_W-1:0]    pg_dir_q;
    logic [CTRL_W-1:0] ctrl_q;

    // Pin synchronisers.
    logic [PORT_W-1:0] pa_s1_q;
    logic [PORT_W-1:0] pa_s2_q;
    logic [PORT_W-1:0] pb_s1_q;
    logic [PORT_W-1:0] pb_s2_q;
    logic [PORT_W-1:0] pc_s1_q;
    logic [PORT_W-1:0] pc_s2_q;
    logic [G_W-1:0]    pg_s1_q;
    logic [G_W-1:0]    pg_s2_q;

    // Bus and override signals.
    logic              bus_req;
    logic              wr_en;
    logic [DAT_W-1:0]  rd_d;
    logic [G_W-1:0]    pg_lvl;
    logic              async_sel;
    logic              extck_sel;
    logic              xmem_en;
    logic [G_W-1:0]    g_pu_oe;
    logic [G_W-1:0]    g_dd_oe;
    logic [G_W-1:0]    g_dd_ov;
    logic [G_W-1:0]    g_pv_oe;
    logic [G_W-1:0]    g_pv_ov;
    logic [G_W-1:0]    g_ie_oe;
    logic [G_W-1:0]    g_ie_ov;

    // Control bits picked out of the control register.
    assign async_sel = ctrl_q[CTRL_ASYNC_BIT];
    assign extck_sel = ctrl_q[CTRL_EXTCK_BIT];
    assign xmem_en   = ctrl_q[CTRL_XMEM_BIT];

    // A request is taken once; the standing ack blocks a second take.
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];

    // Bus answer: one cycle after the request, for one cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= DAT_ZERO;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_d : DAT_ZERO;
        end
    end

    // Two flops on every pin input; only the second is read by logic.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_s1_q <= PORT_RST;
            pa_s2_q <= PORT_RST;
            pb_s1_q <= PORT_RST;
            pb_s2_q <= PORT_RST;
            pc_s1_q <= PORT_RST;
            pc_s2_q <= PORT_RST;
            pg_s1_q <= G_RST;
            pg_s2_q <= G_RST;
        end else begin
            pa_s1_q <= pa_in_i;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= pb_in_i;
            pb_s2_q <= pb_s1_q;
            pc_s1_q <= pc_in_i;
            pc_s2_q <= pc_s1_q;
            pg_s1_q <= pg_in_i;
            pg_s2_q <= pg_s1_q;
        end
    end

    // A pin with its digital input disabled reads as zero.
    assign pg_lvl = pg_s2_q & pg_ie_o;

    // Register writes; only byte lane 0 carries data.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_latch_q <= PORT_RST;
            pa_dir_q   <= PORT_RST;
            pb_latch_q <= PORT_RST;
            pb_dir_q   <= PORT_RST;
            pc_latch_q <= PORT_RST;
            pc_dir_q   <= PORT_RST;
            pg_latch_q <= G_RST;
            pg_dir_q   <= G_RST;
            ctrl_q     <= CTRL_RST;
        end else if (wr_en) begin
            case (wb_adr_i)
                OFS_A_LATCH: pa_latch_q <= wb_dat_i[PORT_W-1:0];
                OFS_A_DIR:   pa_dir_q   <= wb_dat_i[PORT_W-1:0];
                OFS_B_LATCH: pb_latch_q <= wb_dat_i[PORT_W-1:0];
                OFS_B_DIR:   pb_dir_q   <= wb_dat_i[PORT_W-1:0];
                OFS_C_LATCH: pc_latch_q <= wb_dat_i[PORT_W-1:0];
                OFS_C_DIR:   pc_dir_q   <= wb_dat_i[PORT_W-1:0];
                OFS_G_LATCH: pg_latch_q <= wb_dat_i[G_W-1:0];
                OFS_G_DIR:   pg_dir_q   <= wb_dat_i[G_W-1:0];
                OFS_CTRL:    ctrl_q     <= wb_dat_i[CTRL_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped addresses and pin level writes are harmless.
    always_comb begin
        rd_d = DAT_ZERO;
        case (wb_adr_i)
            OFS_A_LATCH: rd_d[PORT_W-1:0] = pa_latch_q;
            OFS_A_DIR:   rd_d[PORT_W-1:0] = pa_dir_q;
            OFS_A_PINS:  rd_d[PORT_W-1:0] = pa_s2_q;
            OFS_B_LATCH: rd_d[PORT_W-1:0] = pb_latch_q;
            OFS_B_DIR:   rd_d[PORT_W-1:0] = pb_dir_q;
            OFS_B_PINS:  rd_d[PORT_W-1:0] = pb_s2_q;
            OFS_C_LATCH: rd_d[PORT_W-1:0] = pc_latch_q;
            OFS_C_DIR:   rd_d[PORT_W-1:0] = pc_dir_q;
            OFS_C_PINS:  rd_d[PORT_W-1:0] = pc_s2_q;
            OFS_G_LATCH: rd_d[G_W-1:0]    = pg_latch_q;
            OFS_G_DIR:   rd_d[G_W-1:0]    = pg_dir_q;
            OFS_G_PINS:  rd_d[G_W-1:0]    = pg_lvl;
            OFS_CTRL:    rd_d[CTRL_W-1:0] = ctrl_q;
            default:     rd_d             = DAT_ZERO;
        endcase
    end

    // Port G override enables; all override values not set here are zero.
    always_comb begin
        g_pu_oe = G_RST;
        g_dd_oe = G_RST;
        g_dd_ov = G_RST;
        g_pv_oe = G_RST;
        g_pv_ov = G_RST;
        g_ie_oe = G_RST;
        g_ie_ov = G_RST;
        // Oscillator input: pull-up and driver off, input per clock mode.
        g_pu_oe[G_OSC_IN]  = async_sel;
        g_dd_oe[G_OSC_IN]  = async_sel;
        g_ie_oe[G_OSC_IN]  = async_sel;
        g_ie_ov[G_OSC_IN]  = extck_sel;
        // Oscillator output: input off with the async select; pull-up and driver off only with the external clock select as well.
        g_pu_oe[G_OSC_OUT] = async_sel & extck_sel;
        g_dd_oe[G_OSC_OUT] = async_sel & extck_sel;
        g_ie_oe[G_OSC_OUT] = async_sel;
        // Memory strobes: forced outputs with pull-ups off.
        g_pu_oe[G_ALE] = xmem_en;
        g_dd_oe[G_ALE] = xmem_en;
        g_dd_ov[G_ALE] = 1'b1;
        g_pv_oe[G_ALE] = xmem_en;
        g_pv_ov[G_ALE] = mem_ale_i;
        g_pu_oe[G_RD]  = xmem_en;
        g_dd_oe[G_RD]  = xmem_en;
        g_dd_ov[G_RD]  = 1'b1;
        g_pv_oe[G_RD]  = xmem_en;
        g_pv_ov[G_RD]  = mem_rd_i;
        g_pu_oe[G_WR]  = xmem_en;
        g_dd_oe[G_WR]  = xmem_en;
        g_dd_ov[G_WR]  = 1'b1;
        g_pv_oe[G_WR]  = xmem_en;
        g_pv_ov[G_WR]  = mem_wr_i;
    end

    // Oscillator routing follows the async select, registered like pins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_in_route_o  <= 1'b0;
            osc_out_route_o <= 1'b0;
        end else begin
            osc_in_route_o  <= async_sel;
            osc_out_route_o <= async_sel;
        end
    end

    // Ports A to C have no alternate functions in this block.
    pgo_pin_ovr #(.W(PORT_W)) u_pa (
        .clk_i(clk_i), .rst_i(rst_i), .latch_i(pa_latch_q),
        .dir_i(pa_dir_q), .pu_oe_i(PORT_RST), .pu_ov_i(PORT_RST),
        .dd_oe_i(PORT_RST), .dd_ov_i(PORT_RST), .pv_oe_i(PORT_RST),
        .pv_ov_i(PORT_RST), .ie_oe_i(PORT_RST), .ie_ov_i(PORT_RST),
        .pad_out_o(pa_out_o), .pad_oe_o(pa_oe_o), .pullup_o(pa_pu_o),
        .in_en_o()
    );

    pgo_pin_ovr #(.W(PORT_W)) u_pb (
        .clk_i(clk_i), .rst_i(rst_i), .latch_i(pb_latch_q),
        .dir_i(pb_dir_q), .pu_oe_i(PORT_RST), .pu_ov_i(PORT_RST),
        .dd_oe_i(PORT_RST), .dd_ov_i(PORT_RST), .pv_oe_i(PORT_RST),
        .pv_ov_i(PORT_RST), .ie_oe_i(PORT_RST), .ie_ov_i(PORT_RST),
        .pad_out_o(pb_out_o), .pad_oe_o(pb_oe_o), .pullup_o(pb_pu_o),
        .in_en_o()
    );

    pgo_pin_ovr #(.W(PORT_W)) u_pc (
        .clk_i(clk_i), .rst_i(rst_i), .latch_i(pc_latch_q),
        .dir_i(pc_dir_q), .pu_oe_i(PORT_RST), .pu_ov_i(PORT_RST),
        .dd_oe_i(PORT_RST), .dd_ov_i(PORT_RST), .pv_oe_i(PORT_RST),
        .pv_ov_i(PORT_RST), .ie_oe_i(PORT_RST), .ie_ov_i(PORT_RST),
        .pad_out_o(pc_out_o), .pad_oe_o(pc_oe_o), .pullup_o(pc_pu_o),
        .in_en_o()
    );

    // Port G carries the oscillator and memory overrides.
    pgo_pin_ovr #(.W(G_W)) u_pg (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .latch_i   (pg_latch_q),
        .dir_i     (pg_dir_q),
        .pu_oe_i   (g_pu_oe),
        .pu_ov_i   (G_RST),
        .dd_oe_i   (g_dd_oe),
        .dd_ov_i   (g_dd_ov),
        .pv_oe_i   (g_pv_oe),
        .pv_ov_i   (g_pv_ov),
        .ie_oe_i   (g_ie_oe),
        .ie_ov_i   (g_ie_ov),
        .pad_out_o (pg_out_o),
        .pad_oe_o  (pg_oe_o),
        .pullup_o  (pg_pu_o),
        .in_en_o   (pg_ie_o)
    );

    // Checks on pin attributes one cycle after their cause, then on register reset values and pin sampling, then on G2 as plain I/O and the bus ack.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_g4_osc_in: assert property (
        async_sel |=> !pg_oe_o[G_OSC_IN] && !pg_pu_o[G_OSC_IN]
                      && osc_in_route_o)
        else $error("G4 not released to oscillator");

    chk_g4_input_en: assert property (
        async_sel |=> pg_ie_o[G_OSC_IN] == $past(extck_sel))
        else $error("G4 input enable does not follow clock select");

    chk_g3_osc_out: assert property (
        async_sel |=> !pg_ie_o[G_OSC_OUT] && osc_out_route_o)
        else $error("G3 not released to oscillator");

    chk_g3_both_sel: assert property (
        async_sel && extck_sel |=> !pg_oe_o[G_OSC_OUT]
                                   && !pg_pu_o[G_OSC_OUT])
        else $error("G3 pull-up or driver left on");

    chk_ale_strobe: assert property (
        xmem_en |=> pg_oe_o[G_ALE] && !pg_pu_o[G_ALE]
                    && pg_out_o[G_ALE] == $past(mem_ale_i))
        else $error("G2 does not carry latch strobe");

    chk_rd_strobe: assert property (
        xmem_en |=> pg_oe_o[G_RD] && !pg_pu_o[G_RD]
                    && pg_out_o[G_RD] == $past(mem_rd_i))
        else $error("G1 does not carry read strobe");

    chk_wr_strobe: assert property (
        xmem_en |=> pg_oe_o[G_WR] && !pg_pu_o[G_WR]
                    && pg_out_o[G_WR] == $past(mem_wr_i))
        else $error("G0 does not carry write strobe");

    chk_latch_reset: assert property (
        $fell(rst_i) |-> pa_latch_q == PORT_RST
                         && pb_latch_q == PORT_RST
                         && pc_latch_q == PORT_RST)
        else $error("Data register not zero after reset");

    chk_dir_reset: assert property (
        $fell(rst_i) |-> pa_dir_q == PORT_RST && pb_dir_q == PORT_RST
                         && pc_dir_q == PORT_RST)
        else $error("Direction register not zero after reset");

    chk_pin_sample: assert property (
        !$past(rst_i) && !$past(rst_i, 2)
            |-> pa_s2_q == $past(pa_in_i, 2))
        else $error("Pin level not two cycles behind pin");

    chk_plain_gpio: assert property (
        !xmem_en |=> pg_oe_o[G_ALE] == $past(pg_dir_q[G_ALE])
                     && pg_out_o[G_ALE] == $past(pg_latch_q[G_ALE]))
        else $error("G2 not following its registers");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus ack longer than one cycle");

    cov_osc_mode: cover property (async_sel && extck_sel);
    cov_xmem_mode: cover property (xmem_en ##1 pg_out_o[G_RD]);
    cov_reg_write: cover property (wr_en && wb_adr_i == OFS_A_DIR);

endmodule : pgo_top

// ===== bench/pgo_ext_model.sv
// Model of the parts beyond port G: a watch crystal and a data memory.
// Assumes the port G pin controls come from the block on clk_i.
`timescale 1ns/1ps
module pgo_ext_model
    import pgo_pkg::*;
(
    // Clock.
    input  wire logic           clk_i,
    // Pin controls from the block.
    input  wire logic [G_W-1:0] pg_out_i,
    input  wire logic [G_W-1:0] pg_oe_i,
    input  wire logic [G_W-1:0] pg_pu_i,
    input  wire logic           osc_in_route_i,
    // Pin levels seen by the block.
    output logic      [G_W-1:0] pg_lvl_o
);
    logic [G_W-1:0] float_q = '0;
    logic           xtal_q  = 1'b0;

    // A floating line flips every cycle, so no stale level can pass.
    always_ff @(posedge clk_i) begin
        float_q <= ~pg_lvl_o;
        xtal_q  <= ~xtal_q;
    end

    // The memory only listens to its strobes; the crystal swings its pin.
    always_comb begin
        for (int i = 0; i < G_W; i++) begin
            if (pg_oe_i[i]) begin
                pg_lvl_o[i] = pg_out_i[i];
            end else if (osc_in_route_i && i == G_OSC_IN) begin
                pg_lvl_o[i] = xtal_q;
            end else if (pg_pu_i[i]) begin
                pg_lvl_o[i] = 1'b1;
            end else begin
                pg_lvl_o[i] = float_q[i];
            end
        end
    end
endmodule : pgo_ext_model

// ===== bench/tb.sv
// Self-checking bench for the port registers and port G overrides.
// Assumes the block answers each Wishbone request with a one-cycle ack.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("FAIL %0t got %h exp %h", $time, got, exp); \
    end \
end
module tb
    import pgo_pkg::*;
;
    logic                clk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                wb_cyc = 1'b0;
    logic                wb_stb = 1'b0;
    logic                wb_we = 1'b0;
    logic [ADR_W-1:0]    wb_adr = '0;
    logic [3:0]          wb_sel = '0;
    logic [DAT_W-1:0]    wb_dat = '0;
    logic [DAT_W-1:0]    wb_dat_o;
    logic                wb_ack_o;
    logic [2:0]          mem = '0;
    logic [PORT_W-1:0]   p_in [3] = '{8'h00, 8'h00, 8'h00};
    logic [PORT_W-1:0]   p_out [3];
    logic [PORT_W-1:0]   p_oe [3];
    logic [PORT_W-1:0]   p_pu [3];
    logic [G_W-1:0]      pg_in, pg_out, pg_oe, pg_pu, pg_ie;
    logic                osc_in, osc_out;
    logic [DAT_W-1:0]    rd;
    int                  error_cnt = 0;
    int                  checked = 0;
    logic [ADR_W-1:0]    lat_ofs [3] =
        '{OFS_A_LATCH, OFS_B_LATCH, OFS_C_LATCH};
    logic [ADR_W-1:0]    dir_ofs [3] = '{OFS_A_DIR, OFS_B_DIR, OFS_C_DIR};
    logic [ADR_W-1:0]    pin_ofs [3] = '{OFS_A_PINS, OFS_B_PINS, OFS_C_PINS};

    // Clock at 125 MHz.
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    pgo_top pgo_top_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .mem_ale_i(mem[2]), .mem_rd_i(mem[1]), .mem_wr_i(mem[0]),
        .pa_in_i(p_in[0]), .pa_out_o(p_out[0]), .pa_oe_o(p_oe[0]),
        .pa_pu_o(p_pu[0]), .pb_in_i(p_in[1]), .pb_out_o(p_out[1]),
        .pb_oe_o(p_oe[1]), .pb_pu_o(p_pu[1]), .pc_in_i(p_in[2]),
        .pc_out_o(p_out[2]), .pc_oe_o(p_oe[2]), .pc_pu_o(p_pu[2]),
        .pg_in_i(pg_in), .pg_out_o(pg_out), .pg_oe_o(pg_oe),
        .pg_pu_o(pg_pu), .pg_ie_o(pg_ie), .osc_in_route_o(osc_in),
        .osc_out_route_o(osc_out));

    pgo_ext_model pgo_ext_model_i (
        .clk_i(clk_i), .pg_out_i(pg_out), .pg_oe_i(pg_oe), .pg_pu_i(pg_pu),
        .osc_in_route_i(osc_in), .pg_lvl_o(pg_in));

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // One classic cycle; a clock edge passes first so strobes fall a cycle.
    task automatic wb(input logic we, input logic [ADR_W-1:0] adr,
                      input logic [7:0] d, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            $display("FAIL %0t no ack", $time);
            stop_test();
        end
    endtask : wb

    task automatic wr(input logic [ADR_W-1:0] adr, input logic [7:0] d);
        wb(1'b1, adr, d, 4'h1);
    endtask : wr

    task automatic rr(input logic [ADR_W-1:0] adr);
        wb(1'b0, adr, 8'h00, 4'h1);
    endtask : rr

    // Waits until a register write has reached the pins.
    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask : settle

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            rr(lat_ofs[k]); `CHK(rd, DAT_ZERO)
            rr(dir_ofs[k]); `CHK(rd, DAT_ZERO)
            `CHK(p_oe[k], PORT_RST)
        end
        $display("reset values done");
        // Data, direction and pin level registers of ports A to C.
        for (int k = 0; k < 3; k++) begin
            p_in[k] <= 8'h5a + 8'(k);
            wr(lat_ofs[k], 8'ha5);
            wr(dir_ofs[k], 8'h0f);
            wb(1'b1, lat_ofs[k], 8'h33, 4'h0);
            rr(lat_ofs[k]); `CHK(rd, 32'h0000_00a5)
            rr(dir_ofs[k]); `CHK(rd, 32'h0000_000f)
            settle();
            `CHK(p_oe[k], 8'h0f)
            `CHK(p_pu[k], 8'ha0)
            `CHK(p_out[k] & 8'h0f, 8'h05)
            wr(pin_ofs[k], 8'hff);
            rr(pin_ofs[k]); `CHK(rd, {24'h000000, 8'h5a + 8'(k)})
        end
        wr(8'h3c, 8'hff);
        rr(8'h3c); `CHK(rd, DAT_ZERO)
        $display("port registers done");
        // Oscillator hand-over of G4 and G3.
        wr(OFS_G_LATCH, 8'h1f);
        wr(OFS_G_DIR, 8'h10);
        settle();
        `CHK(pg_oe[4:3], 2'b10)
        wr(OFS_CTRL, 8'h01);
        settle();
        `CHK(osc_in, 1'b1)
        `CHK(osc_out, 1'b1)
        `CHK(pg_oe[4], 1'b0)
        `CHK(pg_ie[4:3], 2'b00)
        `CHK(pg_pu[3], 1'b1)
        rr(OFS_G_PINS); `CHK(rd, 32'h0000_0007)
        wr(OFS_CTRL, 8'h03);
        wr(OFS_G_DIR, 8'h08);
        settle();
        `CHK(pg_ie[4:3], 2'b10)
        `CHK(pg_pu[4:3], 2'b00)
        `CHK(pg_oe[4:3], 2'b00)
        wr(OFS_CTRL, 8'h00);
        settle();
        `CHK({osc_in, osc_out}, 2'b00)
        `CHK(pg_oe[4:3], 2'b01)
        $display("oscillator done");
        // Memory strobes take over G2 to G0.
        wr(OFS_G_DIR, 8'h00);
        wr(OFS_CTRL, 8'h04);
        settle();
        `CHK(pg_oe[2:0], 3'h7)
        `CHK(pg_pu[2:0], 3'h0)
        for (int v = 0; v < 8; v++) begin
            mem <= 3'(v);
            repeat (2) @(posedge clk_i);
            `CHK(pg_out[2:0], 3'(v))
        end
        mem <= 3'h0;
        wr(OFS_CTRL, 8'h00);
        settle();
        `CHK(pg_oe[2:0], 3'h0)
        `CHK(pg_out[2:0], 3'h7)
        `CHK(pg_pu[2:0], 3'h7)
        $display("memory strobes done");
        stop_test();
    end
endmodule : tb
